/* File: logic/art_params.svh */
// Purpose: Register indices, field positions and fixed values of the capture timer
// Assumes: Included by the timer module and the bench
// Notes: Byte address of a register is four times its index
`ifndef ART_PARAMS_SVH
`define ART_PARAMS_SVH

// ==========================================================================
// Register indices
`define ART_IDX_CAPCTL 8'hE1
`define ART_IDX_CAPCTL2 8'hE2
`define ART_IDX_MAIN 8'hE8
`define ART_IDX_RELOAD_CAPTURE_VALUE 8'hE9
`define ART_IDX_CAPV 8'hEB
`define ART_IDX_COUNT 8'hF0

// ==========================================================================
// Field positions of timer_main_control
`define ART_MAIN_PSC_HI 7
`define ART_MAIN_PSC_LO 6
`define ART_MAIN_RELOAD 5
`define ART_MAIN_RUN 4
`define ART_MAIN_OVF_IE 3
`define ART_MAIN_OVF_FLG 2
`define ART_MAIN_OVF_MD 1

// ==========================================================================
// Field positions of capture_status_control
`define ART_CAP_ERR1 6
`define ART_CAP_ERR2 5
`define ART_CAP_IE1 4
`define ART_CAP_FLG1 3
`define ART_CAP_POL1 2
`define ART_CAP_SEL_HI 1
`define ART_CAP_SEL_LO 0

// ==========================================================================
// Field positions of the second capture control register
`define ART_CAP2_POL2 7
`define ART_CAP2_IE2 6
`define ART_CAP2_FLG2 5
`define ART_CAP2_CMP_IE 4
`define ART_CAP2_CMP_FLG 3
`define ART_CAP2_ZERO_IE 2
`define ART_CAP2_ZERO_FLG 1

// ==========================================================================
// Reset values and constants
`define ART_RST_WORD 16'h0000
`define ART_ALL_ONES 16'hFFFF
`define ART_PSC_TC1 4'h0
`define ART_PSC_TC4 4'h3
`define ART_PSC_TC16 4'hF

`endif

/* File: logic/art_pkg.sv */
// Purpose: Types shared by the capture timer and its bench
// Assumes: Nothing
// Notes: Whole module state lives in one packed struct
package art_pkg;

  // ========================================================================
  // Bus handshake phase
  typedef enum logic [0:0] {
    ART_BUS_IDLE = 1'b0,
    ART_BUS_ACK = 1'b1
  } art_bus_e;

  // ========================================================================
  // Reload source select of capture_status_control
  typedef enum logic [1:0] {
    ART_SEL_SW = 2'h0,
    ART_SEL_IN1 = 2'h1,
    ART_SEL_IN2 = 2'h2,
    ART_SEL_OFF = 2'h3
  } art_rsel_e;

  // ========================================================================
  // Avalon-MM request from the master
  typedef struct packed {
    logic [9:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } art_avs_req_s;

  // ========================================================================
  // Complete module state
  typedef struct packed {
    art_bus_e phase;
    logic [31:0] rdata;
    logic [1:0] psc;
    logic reload;
    logic run;
    logic ovf_ie;
    logic ovf_flag;
    logic ovf_mode;
    logic err1;
    logic err2;
    logic ie1;
    logic flag1;
    logic pol1;
    art_rsel_e sel;
    logic pol2;
    logic ie2;
    logic flag2;
    logic cmp_ie;
    logic cmp_flag;
    logic zero_ie;
    logic zero_flag;
    logic [15:0] reload_capture_value;
    logic [15:0] capv;
    logic [15:0] cnt;
    logic [3:0] pre;
    logic in1_prev;
    logic in2_prev;
    logic ovf_pin;
  } art_state_s;

endpackage

/* File: logic/art_timer.sv */
// Purpose: Auto-reload down counter with restart modes and dual capture
// Assumes: Capture inputs synchronous to sys_clk; Avalon-MM slave, one wait state
// Notes: Compare and masked-zero events come from the signal generation part
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "art_params.svh"

module art_timer (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire art_pkg::art_avs_req_s avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic first_capture_input,
  input wire logic second_capture_input,
  input wire logic compare_match_event,
  input wire logic masked_zero_event,
  output logic overflow_output_pin,
  output logic timer_irq
);

  // ========================================================================
  // Decode helpers
  function automatic logic art_hit(input logic [9:0] addr, input logic [7:0] idx);
    art_hit = (addr[9:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  // Read multiplexer; unmapped addresses and reserved bits read zero
  function automatic logic [31:0] art_rd(input art_pkg::art_state_s s,
                                         input logic [9:0] addr);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (art_hit(addr, `ART_IDX_MAIN)) begin
      d[7:0] = {s.psc, s.reload, s.run, s.ovf_ie, s.ovf_flag, s.ovf_mode, 1'b0};
    end else if (art_hit(addr, `ART_IDX_CAPCTL)) begin
      d[7:0] = {1'b0, s.err1, s.err2, s.ie1, s.flag1, s.pol1, s.sel};
    end else if (art_hit(addr, `ART_IDX_CAPCTL2)) begin
      d[7:0] = {s.pol2, s.ie2, s.flag2, s.cmp_ie, s.cmp_flag, s.zero_ie, s.zero_flag, 1'b0};
    end else if (art_hit(addr, `ART_IDX_RELOAD_CAPTURE_VALUE)) begin
      d[15:0] = s.reload_capture_value;
    end else if (art_hit(addr, `ART_IDX_CAPV)) begin
      d[15:0] = s.capv;
    end else if (art_hit(addr, `ART_IDX_COUNT)) begin
      d[15:0] = s.cnt;
    end
    art_rd = d;
  endfunction

  art_pkg::art_state_s state_ff;
  art_pkg::art_state_s nxt_state;
  logic req;
  logic wr_en;
  logic wr_main;
  logic wr_cap;
  logic wr_cap2;
  logic wr_reload_capture_value;
  logic [7:0] wd;
  logic rel_on;
  logic tick;
  logic ovf_evt;
  logic edge1;
  logic edge2;
  logic sw_start;
  logic [3:0] psc_tc;

  // ========================================================================
  // Next-state logic
  always_comb begin
    nxt_state = state_ff;
    req = avs_req.read | avs_req.write;
    wr_en = avs_req.write && (state_ff.phase == art_pkg::ART_BUS_ACK) &&
            avs_req.byteenable[0];
    wr_main = wr_en && art_hit(avs_req.address, `ART_IDX_MAIN);
    wr_cap = wr_en && art_hit(avs_req.address, `ART_IDX_CAPCTL);
    wr_cap2 = wr_en && art_hit(avs_req.address, `ART_IDX_CAPCTL2);
    wr_reload_capture_value = avs_req.write && (state_ff.phase == art_pkg::ART_BUS_ACK) &&
              art_hit(avs_req.address, `ART_IDX_RELOAD_CAPTURE_VALUE);
    wd = avs_req.writedata[7:0];
    rel_on = state_ff.reload && (state_ff.sel != art_pkg::ART_SEL_OFF);
    tick = 1'b0;
    ovf_evt = 1'b0;
    psc_tc = `ART_PSC_TC1;

    // Bus handshake: one wait state, read data latched in the first cycle
    case (state_ff.phase)
      art_pkg::ART_BUS_IDLE: begin
        if (req) begin
          nxt_state.phase = art_pkg::ART_BUS_ACK;
          nxt_state.rdata = art_rd(state_ff, avs_req.address);
        end
      end
      default: begin
        nxt_state.phase = art_pkg::ART_BUS_IDLE;
      end
    endcase

    // Active edges, only while the run bit enables the input stages
    nxt_state.in1_prev = first_capture_input;
    nxt_state.in2_prev = second_capture_input;
    edge1 = state_ff.run && (state_ff.pol1 ? (first_capture_input && !state_ff.in1_prev) :
            (!first_capture_input && state_ff.in1_prev));
    edge2 = state_ff.run && (state_ff.pol2 ? (second_capture_input && !state_ff.in2_prev) :
            (!second_capture_input && state_ff.in2_prev));

    // Software start: run bit rising while software reload is selected
    sw_start = wr_main && wd[`ART_MAIN_RUN] && !state_ff.run && rel_on &&
               (state_ff.sel == art_pkg::ART_SEL_SW);

    // Control field writes
    if (wr_main) begin
      nxt_state.psc = {wd[`ART_MAIN_PSC_HI], wd[`ART_MAIN_PSC_LO]};
      nxt_state.reload = wd[`ART_MAIN_RELOAD];
      nxt_state.run = wd[`ART_MAIN_RUN];
      nxt_state.ovf_ie = wd[`ART_MAIN_OVF_IE];
      nxt_state.ovf_mode = wd[`ART_MAIN_OVF_MD];
      if (!wd[`ART_MAIN_OVF_FLG]) begin
        nxt_state.ovf_flag = 1'b0;
      end
    end
    if (wr_cap) begin
      nxt_state.ie1 = wd[`ART_CAP_IE1];
      nxt_state.pol1 = wd[`ART_CAP_POL1];
      nxt_state.sel = art_pkg::art_rsel_e'({wd[`ART_CAP_SEL_HI], wd[`ART_CAP_SEL_LO]});
      if (!wd[`ART_CAP_ERR1]) begin
        nxt_state.err1 = 1'b0;
      end
      if (!wd[`ART_CAP_ERR2]) begin
        nxt_state.err2 = 1'b0;
      end
      if (!wd[`ART_CAP_FLG1]) begin
        nxt_state.flag1 = 1'b0;
      end
    end
    if (wr_cap2) begin
      nxt_state.pol2 = wd[`ART_CAP2_POL2];
      nxt_state.ie2 = wd[`ART_CAP2_IE2];
      nxt_state.cmp_ie = wd[`ART_CAP2_CMP_IE];
      nxt_state.zero_ie = wd[`ART_CAP2_ZERO_IE];
      if (!wd[`ART_CAP2_FLG2]) begin
        nxt_state.flag2 = 1'b0;
      end
      if (!wd[`ART_CAP2_CMP_FLG]) begin
        nxt_state.cmp_flag = 1'b0;
      end
      if (!wd[`ART_CAP2_ZERO_FLG]) begin
        nxt_state.zero_flag = 1'b0;
      end
    end
    // Reload value is writable only while reloads are enabled
    if (wr_reload_capture_value && state_ff.reload) begin
      if (avs_req.byteenable[0]) begin
        nxt_state.reload_capture_value[7:0] = avs_req.writedata[7:0];
      end
      if (avs_req.byteenable[1]) begin
        nxt_state.reload_capture_value[15:8] = avs_req.writedata[15:8];
      end
    end

    // Prescaler: stopped and cleared when disabled or not running
    case (state_ff.psc)
      2'h2: psc_tc = `ART_PSC_TC4;
      2'h3: psc_tc = `ART_PSC_TC16;
      default: psc_tc = `ART_PSC_TC1;
    endcase
    if (!state_ff.run || (state_ff.psc == 2'h0)) begin
      nxt_state.pre = 4'h0;
    end else if (state_ff.pre >= psc_tc) begin
      nxt_state.pre = 4'h0;
      tick = 1'b1;
    end else begin
      nxt_state.pre = state_ff.pre + 4'h1;
    end

    // Down counter
    if (!state_ff.run) begin
      nxt_state.cnt = sw_start ? state_ff.reload_capture_value : `ART_RST_WORD;
    end else if (tick) begin
      if (state_ff.cnt == `ART_RST_WORD) begin
        ovf_evt = 1'b1;
        nxt_state.cnt = rel_on ? state_ff.reload_capture_value : `ART_ALL_ONES;
      end else begin
        nxt_state.cnt = state_ff.cnt - 16'h0001;
      end
    end

    // First input: reload, flag, overrun or free-run capture
    if (edge1 && rel_on && (state_ff.sel == art_pkg::ART_SEL_IN1)) begin
      nxt_state.cnt = state_ff.reload_capture_value;
    end
    if (edge1 && !state_ff.err1) begin
      if (state_ff.flag1) begin
        nxt_state.err1 = 1'b1;
      end else begin
        nxt_state.flag1 = 1'b1;
        if (!state_ff.reload) begin
          nxt_state.reload_capture_value = state_ff.cnt;
        end
      end
    end

    // Second input: capture of the pre-reload count, then optional reload
    if (edge2 && !state_ff.err2) begin
      if (state_ff.flag2) begin
        nxt_state.err2 = 1'b1;
      end else begin
        nxt_state.capv = state_ff.cnt;
        nxt_state.flag2 = 1'b1;
      end
    end
    if (edge2 && rel_on && (state_ff.sel == art_pkg::ART_SEL_IN2)) begin
      nxt_state.cnt = state_ff.reload_capture_value;
    end
    if (wr_main && !wd[`ART_MAIN_RUN]) begin
      nxt_state.cnt = `ART_RST_WORD;
    end

    // Flags from the signal generation part
    if (compare_match_event) begin
      nxt_state.cmp_flag = 1'b1;
    end
    if (masked_zero_event) begin
      nxt_state.zero_flag = 1'b1;
    end

    // Overflow flag and pin; a set beats a clear in the same cycle
    if (ovf_evt) begin
      nxt_state.ovf_flag = 1'b1;
      nxt_state.ovf_pin = state_ff.ovf_mode ? !state_ff.ovf_pin : 1'b1;
    end
    if (!nxt_state.ovf_mode && !nxt_state.ovf_flag) begin
      nxt_state.ovf_pin = 1'b0;
    end
  end

  // ========================================================================
  // State register; everything clears, prescaler ends disabled
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ========================================================================
  // Outputs
  assign avs_waitrequest = req && (state_ff.phase != art_pkg::ART_BUS_ACK);
  assign avs_readdata = state_ff.rdata;
  assign overflow_output_pin = state_ff.ovf_pin;
  assign timer_irq = (state_ff.flag1 && state_ff.ie1) ||
                     (state_ff.flag2 && state_ff.ie2) ||
                     (state_ff.ovf_flag && state_ff.ovf_ie) ||
                     (state_ff.cmp_flag && state_ff.cmp_ie) ||
                     (state_ff.zero_flag && state_ff.zero_ie);

  // ========================================================================
  // Assertions
  default clocking art_cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_stopped;
    !state_ff.run ##1 !state_ff.run;
  endsequence

  sequence s_cap2_ok;
    edge2 && !state_ff.flag2 && !state_ff.err2;
  endsequence

  sequence s_cap2_ovr;
    edge2 && state_ff.flag2 && !state_ff.err2;
  endsequence

  a_run_clear_hold: assert property (s_stopped |-> (state_ff.cnt == 16'h0000))
    else $error("Counter not held at zero while stopped");

  a_cap2_take: assert property (s_cap2_ok |=> state_ff.flag2 &&
      (state_ff.capv == $past(state_ff.cnt)))
    else $error("Second capture did not take the count");

  a_cap2_overrun: assert property (s_cap2_ovr |=> state_ff.err2 &&
      $stable(state_ff.capv))
    else $error("Second overrun missed or capture not blocked");

  a_fr_cap1: assert property (edge1 && !state_ff.reload && !state_ff.flag1 &&
      !state_ff.err1 |=> state_ff.flag1 &&
      (state_ff.reload_capture_value == $past(state_ff.cnt)))
    else $error("Free-run first capture wrong");

  a_in1_reload: assert property (edge1 && state_ff.reload && state_ff.run &&
      (state_ff.sel == art_pkg::ART_SEL_IN1) && !wr_main |=>
      (state_ff.cnt == $past(state_ff.reload_capture_value)))
    else $error("First-input reload missed");

  a_ovf_flag_set: assert property (ovf_evt |=> state_ff.ovf_flag)
    else $error("Overflow flag not set");

  a_ovf_toggle: assert property (ovf_evt && state_ff.ovf_mode && !wr_main |=>
      (overflow_output_pin != $past(overflow_output_pin)))
    else $error("Overflow pin did not toggle");

  a_ovf_pin_clear: assert property (!state_ff.ovf_mode && !state_ff.ovf_flag |->
      !overflow_output_pin)
    else $error("Overflow pin high without flag");

  a_irq_enable: assert property ($rose(state_ff.ovf_ie) && state_ff.ovf_flag |->
      timer_irq)
    else $error("Interrupt not raised on late enable");

  a_div_four: assert property (tick && (state_ff.psc == 2'h2) |=> (!tick) [*3])
    else $error("Divide-by-four tick spacing wrong");

  a_bus_wait: assert property (req && (state_ff.phase == art_pkg::ART_BUS_IDLE) |->
      avs_waitrequest ##1 !avs_waitrequest)
    else $error("Bus answer not after one wait state");

  // Reload value is read only while reloads are off, apart from a first-input capture
  a_reload_capture_value_lock: assert property (wr_reload_capture_value && !state_ff.reload && !edge1 |=>
      $stable(state_ff.reload_capture_value))
    else $error("Reload value written while reloads off");

  // Second-input restart reloads whether or not a capture happens
  a_cap2_reload: assert property (edge2 && rel_on && (state_ff.sel == art_pkg::ART_SEL_IN2) &&
      !wr_main |=> (state_ff.cnt == $past(state_ff.reload_capture_value)))
    else $error("Second-input reload missed");

  // Software start loads the reload value and leaves the counter running
  a_sw_start: assert property (sw_start |=> state_ff.run &&
      (state_ff.cnt == $past(state_ff.reload_capture_value)))
    else $error("Software start did not reload");

  // With reloads off the counter wraps from zero to all ones
  a_free_wrap: assert property (tick && state_ff.run && (state_ff.cnt == 16'h0000) &&
      !rel_on && !wr_main |=> (state_ff.cnt == 16'hFFFF))
    else $error("Free-running wrap value wrong");

  // A repeated first-input event while its flag stands raises the overrun
  a_cap1_overrun: assert property (edge1 && state_ff.flag1 && !state_ff.err1 |=>
      state_ff.err1)
    else $error("First overrun missed");

  // Software writes never raise the overflow flag
  a_ovf_no_set: assert property (wr_main && !ovf_evt && !state_ff.ovf_flag |=>
      !state_ff.ovf_flag)
    else $error("Overflow flag set by a write");

  // A disabled prescaler gives no count ticks
  a_psc_stop: assert property ((state_ff.psc == 2'h0) |-> !tick)
    else $error("Tick while prescaler disabled");

  // Enabled second-input flag always reaches the interrupt
  a_irq_cap2: assert property (state_ff.flag2 && state_ff.ie2 |-> timer_irq)
    else $error("Second-input interrupt not raised");

endmodule

/* File: test/art_cap_src.sv */
// Purpose: Far-side model that drives capture edges and outside event pulses
// Assumes: Levels change by non-blocking assignment just after a rising sys_clk edge
// Notes: Inputs are held levels, so no line floats between events
`timescale 1ns/10ps

module art_cap_src (
  input wire logic sys_clk,
  output logic first_capture_input,
  output logic second_capture_input,
  output logic compare_match_event,
  output logic masked_zero_event
);
  // ==========================================================================
  // Idle levels at time zero
  initial begin
    first_capture_input = 1'b0;
    second_capture_input = 1'b0;
    compare_match_event = 1'b0;
    masked_zero_event = 1'b0;
  end

  // Park the chosen inputs at the opposite level, then move them to lv together
  task automatic strobe(input logic [1:0] m, input logic lv);
    @(posedge sys_clk);
    if (m[0]) first_capture_input <= !lv;
    if (m[1]) second_capture_input <= !lv;
    repeat (3) @(posedge sys_clk);
    if (m[0]) first_capture_input <= lv;
    if (m[1]) second_capture_input <= lv;
    repeat (3) @(posedge sys_clk);
  endtask

  // One-cycle compare or zero event pulse
  task automatic pulse(input logic zero);
    @(posedge sys_clk);
    if (zero) masked_zero_event <= 1'b1;
    else compare_match_event <= 1'b1;
    @(posedge sys_clk);
    masked_zero_event <= 1'b0;
    compare_match_event <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
endmodule

/* File: test/tb_top.sv */
// Purpose: Self-checking bench of the capture timer
// Assumes: One wait state per bus access; stopped prescaler makes captures exact
// Notes: Seeded random reload values; prescale checked with one tick of slack, exact when disabled
`timescale 1ns/10ps
`include "art_params.svh"

`define CHK(nm, exp, got) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
  end \
end

module tb_top;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  art_pkg::art_avs_req_s req = '0;
  logic [31:0] rdata, d;
  logic wait_req, ovf_pin, irq, f1, f2, cm, mz, p0;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  int t_acc;
  logic [15:0] rv [1:6];
  logic [15:0] v, b, fl;
  logic [7:0] ix;
  logic [7:0] fl_t [4] = '{8'h08, 8'h20, 8'h08, 8'h02};
  logic [7:0] en_t [4] = '{8'h10, 8'h40, 8'h10, 8'h04};

  // ==========================================================================
  // Clock, cycle count, design and far side
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  art_timer i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .avs_req(req), .avs_readdata(rdata),
    .avs_waitrequest(wait_req), .first_capture_input(f1), .second_capture_input(f2),
    .compare_match_event(cm), .masked_zero_event(mz), .overflow_output_pin(ovf_pin),
    .timer_irq(irq));
  art_cap_src i_src (.sys_clk(sys_clk), .first_capture_input(f1),
    .second_capture_input(f2), .compare_match_event(cm), .masked_zero_event(mz));

  // ==========================================================================
  // Bus master: hold request until waitrequest low, then release
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= '{address: {idx, 2'b00}, read: !wr, write: wr, writedata: wd, byteenable: 4'hF};
    do begin
      @(negedge sys_clk);
      n++;
    end while (wait_req !== 1'b0 && n < 20);
    q = rdata;
    t_acc = cyc;
    if (n >= 20) mismatches++;
    @(posedge sys_clk);
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] val);
    logic [31:0] q;
    bus(1'b1, idx, {16'h0, val}, q);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [15:0] e, input string nm);
    bus(1'b0, idx, 32'h0, d);
    `CHK(nm, {16'h0, e}, d)
  endtask

  // Counter decrement over a measured span must match the prescale factor
  task automatic meas(input logic [1:0] ps, input int div);
    int t0, tol, dd, ed;
    wr(`ART_IDX_MAIN, 16'h10);
    wr(`ART_IDX_MAIN, {8'h0, ps, 6'h10});
    bus(1'b0, `ART_IDX_COUNT, 32'h0, d);
    v = d[15:0];
    t0 = t_acc;
    repeat (60) @(posedge sys_clk);
    bus(1'b0, `ART_IDX_COUNT, 32'h0, d);
    dd = int'(16'(v - d[15:0]));
    ed = (t_acc - t0) / div;
    tol = (div > 100) ? 0 : 1;
    `CHK("count step", 1'b1, (dd >= ed - tol) && (dd <= ed + tol))
  endtask

  // Verdict and end of run
  task automatic close_out;
    $display("Counts: %0d checks, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    close_out();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(8660));
    for (int i = 1; i <= 6; i++) rv[i] = {i[3:0], 12'($urandom)};
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    rdc(`ART_IDX_MAIN, 16'h0, "main");
    rdc(`ART_IDX_CAPCTL, 16'h0, "capctl");
    rdc(`ART_IDX_COUNT, 16'h0, "count");
    rdc(8'h10, 16'h0, "unmapped");
    `CHK("irq", 1'b0, irq)
    $display("Test reset done");
    // Second-input restart with stopped prescaler
    wr(`ART_IDX_MAIN, 16'h20);
    wr(`ART_IDX_RELOAD_CAPTURE_VALUE, rv[1]);
    wr(`ART_IDX_CAPCTL, 16'h06);
    wr(`ART_IDX_CAPCTL2, 16'h80);
    wr(`ART_IDX_MAIN, 16'h30);
    i_src.strobe(2'b10, 1'b1);
    rdc(`ART_IDX_CAPV, 16'h0, "capv");
    rdc(`ART_IDX_COUNT, rv[1], "count");
    rdc(`ART_IDX_CAPCTL2, 16'hA0, "flag2");
    i_src.strobe(2'b01, 1'b1);
    rdc(`ART_IDX_CAPCTL, 16'h0E, "flag1");
    rdc(`ART_IDX_COUNT, rv[1], "count");
    wr(`ART_IDX_RELOAD_CAPTURE_VALUE, rv[2]);
    i_src.strobe(2'b10, 1'b1);
    rdc(`ART_IDX_CAPV, 16'h0, "capv");
    rdc(`ART_IDX_COUNT, rv[2], "count");
    $display("Test second-input restart done");
    // First-input restart
    wr(`ART_IDX_CAPCTL, 16'h05);
    wr(`ART_IDX_CAPCTL2, 16'h80);
    wr(`ART_IDX_RELOAD_CAPTURE_VALUE, rv[3]);
    i_src.strobe(2'b01, 1'b1);
    rdc(`ART_IDX_COUNT, rv[3], "count");
    i_src.strobe(2'b01, 1'b1);
    rdc(`ART_IDX_CAPCTL, 16'h4D, "err1");
    i_src.strobe(2'b10, 1'b1);
    rdc(`ART_IDX_CAPV, rv[3], "capv");
    i_src.strobe(2'b10, 1'b1);
    rdc(`ART_IDX_CAPCTL, 16'h6D, "err2");
    wr(`ART_IDX_RELOAD_CAPTURE_VALUE, rv[4]);
    i_src.strobe(2'b01, 1'b1);
    wr(`ART_IDX_CAPCTL2, 16'h80);
    i_src.strobe(2'b10, 1'b1);
    rdc(`ART_IDX_CAPV, rv[3], "capv");
    wr(`ART_IDX_CAPCTL, 16'h05);
    wr(`ART_IDX_CAPCTL, 16'h45);
    rdc(`ART_IDX_CAPCTL, 16'h05, "err1");
    wr(`ART_IDX_RELOAD_CAPTURE_VALUE, rv[5]);
    i_src.strobe(2'b11, 1'b1);
    rdc(`ART_IDX_CAPV, rv[4], "capv");
    rdc(`ART_IDX_COUNT, rv[5], "count");
    $display("Test first-input restart done");
    // Software restart
    wr(`ART_IDX_MAIN, 16'h20);
    rdc(`ART_IDX_COUNT, 16'h0, "count");
    wr(`ART_IDX_CAPCTL, 16'h04);
    wr(`ART_IDX_RELOAD_CAPTURE_VALUE, rv[6]);
    wr(`ART_IDX_MAIN, 16'h30);
    rdc(`ART_IDX_COUNT, rv[6], "count");
    wr(`ART_IDX_CAPCTL2, 16'h80);
    i_src.strobe(2'b10, 1'b1);
    rdc(`ART_IDX_CAPV, rv[6], "capv");
    $display("Test software restart done");
    // Reload disabled, overflow flag and pin, prescale, free-run capture
    wr(`ART_IDX_MAIN, 16'h00);
    wr(`ART_IDX_CAPCTL, 16'h07);
    wr(`ART_IDX_MAIN, 16'h70);
    rdc(`ART_IDX_MAIN, 16'h74, "ovf flag");
    `CHK("ovf pin", 1'b1, ovf_pin)
    bus(1'b0, `ART_IDX_COUNT, 32'h0, d);
    `CHK("reload off", 4'hF, d[15:12])
    wr(`ART_IDX_MAIN, 16'h70);
    wr(`ART_IDX_MAIN, 16'h74);
    rdc(`ART_IDX_MAIN, 16'h70, "ovf flag");
    `CHK("ovf pin", 1'b0, ovf_pin)
    wr(`ART_IDX_CAPCTL, 16'h04);
    meas(2'b01, 1);
    meas(2'b10, 4);
    meas(2'b11, 16);
    meas(2'b00, 1000000);
    bus(1'b0, `ART_IDX_COUNT, 32'h0, d);
    v = d[15:0];
    i_src.strobe(2'b01, 1'b1);
    wr(`ART_IDX_MAIN, 16'h50);
    wr(`ART_IDX_MAIN, 16'h10);
    i_src.strobe(2'b01, 1'b1);
    rdc(`ART_IDX_RELOAD_CAPTURE_VALUE, v, "reload_capture_value");
    rdc(`ART_IDX_CAPCTL, 16'h4C, "err1");
    wr(`ART_IDX_RELOAD_CAPTURE_VALUE, rv[2]);
    rdc(`ART_IDX_RELOAD_CAPTURE_VALUE, v, "reload_capture_value");
    bus(1'b0, `ART_IDX_COUNT, 32'h0, d);
    wr(`ART_IDX_CAPCTL2, 16'h00);
    i_src.strobe(2'b10, 1'b0);
    rdc(`ART_IDX_CAPV, d[15:0], "capv");
    i_src.strobe(2'b10, 1'b0);
    rdc(`ART_IDX_CAPCTL2, 16'h20, "flag2");
    rdc(`ART_IDX_CAPCTL, 16'h6C, "err2");
    wr(`ART_IDX_MAIN, 16'h00);
    wr(`ART_IDX_MAIN, 16'h20);
    wr(`ART_IDX_RELOAD_CAPTURE_VALUE, 16'h0003);
    wr(`ART_IDX_MAIN, 16'h72);
    @(negedge sys_clk);
    p0 = ovf_pin;
    repeat (4) @(negedge sys_clk);
    `CHK("ovf toggle", !p0, ovf_pin)
    repeat (4) @(negedge sys_clk);
    `CHK("ovf toggle", p0, ovf_pin)
    wr(`ART_IDX_MAIN, 16'h7E);
    @(negedge sys_clk);
    `CHK("irq ovf", 1'b1, irq)
    $display("Test free run done");
    // Each capture, compare and zero flag sets while masked; enabling it raises the interrupt
    wr(`ART_IDX_MAIN, 16'h10);
    wr(`ART_IDX_CAPCTL, 16'h04);
    wr(`ART_IDX_CAPCTL2, 16'h80);
    for (int k = 0; k < 4; k++) begin
      ix = (k == 0) ? `ART_IDX_CAPCTL : `ART_IDX_CAPCTL2;
      b = (k == 0) ? 16'h04 : 16'h80;
      fl = {8'h0, fl_t[k]};
      if (k < 2) i_src.strobe((k == 0) ? 2'b01 : 2'b10, 1'b1);
      else i_src.pulse(k == 3);
      rdc(ix, b | fl, "flag");
      `CHK("irq masked", 1'b0, irq)
      wr(ix, b | fl | {8'h0, en_t[k]});
      @(negedge sys_clk);
      `CHK("irq", 1'b1, irq)
      wr(ix, b);
    end
    $display("Test interrupts done");
    close_out();
  end
endmodule
